/* src/csdec_decoder.sv */
// Purpose: decode a received signal code into state, value and state code
// Assumes: code and type come from logic on the same clock
// Notes: output word loads two edges after the take edge, one request per cycle
//   narrow types read only the low bits of the received code
//   continuous valid value is an unsigned fraction, full scale is all ones
`timescale 1ns/1ps
`include "csdec_params.svh"
module csdec_decoder
  import csdec_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic code_valid_in,
  input wire logic [31:0] received_code_in,
  input csdec_type_t sig_type_in,
  output logic sig_valid_out,
  output csdec_signal_t sig_out
);
  typedef struct packed {
    csdec_state_t state;
    logic [31:0] code;
    logic [31:0] state_code;
    logic cont;
    logic [31:0] max_code;
  } csdec_stage_t;

  csdec_stage_t stage_d;
  csdec_stage_t stage_q;
  csdec_stage_t stage2_q;
  logic valid_q;
  logic valid2_q;
  logic [31:0] norm_code;
  logic [31:0] norm_max;
  logic [31:0] frac;

  // Shared range classifier for all continuous widths
  function automatic csdec_stage_t csdec_cont(input logic [31:0] c, input logic [31:0] spec,
                                               input logic [31:0] err, input logic [31:0] na);
    csdec_stage_t s;
    s = '0;
    s.code = c;
    s.cont = 1'b1;
    s.max_code = spec - `CSDEC_ONE32;
    if (c >= na) begin
      s.state = CSDEC_ST_NA;
    end else if (c >= err) begin
      s.state = CSDEC_ST_ERROR;
      s.state_code = c - err;
    end else if (c >= spec) begin
      s.state = CSDEC_ST_SPECIAL;
      s.state_code = c - spec;
    end else begin
      s.state = CSDEC_ST_VALID;
    end
    return s;
  endfunction : csdec_cont

  // Narrow types read only the low bits; an undefined type reads nothing
  function automatic logic [31:0] csdec_mask(input csdec_type_t t);
    logic [31:0] m;
    m = `CSDEC_ZERO32;
    case (t)
      CSDEC_TYPE_D1: begin
        m = `CSDEC_MASK1;
      end
      CSDEC_TYPE_D2: begin
        m = `CSDEC_MASK2;
      end
      CSDEC_TYPE_D4: begin
        m = `CSDEC_MASK4;
      end
      CSDEC_TYPE_C1: begin
        m = `CSDEC_MASK8;
      end
      CSDEC_TYPE_C2: begin
        m = `CSDEC_MASK16;
      end
      CSDEC_TYPE_C4: begin
        m = ~`CSDEC_ZERO32;
      end
      default: begin
        m = `CSDEC_ZERO32;
      end
    endcase
    return m;
  endfunction : csdec_mask

  // Value is zero outside the valid state; discrete codes pass as integers
  function automatic logic [31:0] csdec_value(input csdec_stage_t s, input logic [31:0] f);
    logic [31:0] v;
    v = `CSDEC_ZERO32;
    if (s.state != CSDEC_ST_VALID) begin
      v = `CSDEC_ZERO32;
    end else if (s.cont) begin
      v = f;
    end else begin
      v = s.code;
    end
    return v;
  endfunction : csdec_value

  always_comb begin
    logic [31:0] c;
    c = received_code_in & csdec_mask(sig_type_in);
    stage_d = '0;
    stage_d.state = CSDEC_ST_NA;
    case (sig_type_in)
      CSDEC_TYPE_D1: begin
        stage_d.state = CSDEC_ST_VALID;
        stage_d.code = c;
      end
      CSDEC_TYPE_D2: begin
        if (c == `CSDEC_D2_NA) begin
          stage_d.state = CSDEC_ST_NA;
        end else if (c == `CSDEC_D2_ERR) begin
          stage_d.state = CSDEC_ST_ERROR;
        end else begin
          stage_d.state = CSDEC_ST_VALID;
          stage_d.code = c;
        end
      end
      CSDEC_TYPE_D4: begin
        if (c == `CSDEC_D4_NA) begin
          stage_d.state = CSDEC_ST_NA;
        end else if (c == `CSDEC_D4_ERR) begin
          stage_d.state = CSDEC_ST_ERROR;
        end else if (c >= `CSDEC_D4_SPEC_LO) begin
          stage_d.state = CSDEC_ST_SPECIAL;
          stage_d.state_code = c - `CSDEC_D4_SPEC_LO;
        end else begin
          stage_d.state = CSDEC_ST_VALID;
          stage_d.code = c;
        end
      end
      CSDEC_TYPE_C1: begin
        stage_d = csdec_cont(c, `CSDEC_C1_SPEC, `CSDEC_C1_ERR, `CSDEC_C1_NA);
      end
      CSDEC_TYPE_C2: begin
        stage_d = csdec_cont(c, `CSDEC_C2_SPEC, `CSDEC_C2_ERR, `CSDEC_C2_NA);
      end
      CSDEC_TYPE_C4: begin
        stage_d = csdec_cont(c, `CSDEC_C4_SPEC, `CSDEC_C4_ERR, `CSDEC_C4_NA);
      end
      default: begin
        stage_d.state = CSDEC_ST_NA;
      end
    endcase
  end

  // Request flag walks beside its data; nothing is refused
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= code_valid_in;
    end
  end

  // Held between requests, so the divider input only moves on a new code
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stage_q <= '0;
    end else if (code_valid_in) begin
      stage_q <= stage_d;
    end
  end

  // Divider sees zero unless the code is valid and continuous, to save toggling
  always_comb begin
    norm_code = `CSDEC_ZERO32;
    norm_max = `CSDEC_ONE32;
    if (stage_q.cont && stage_q.state == CSDEC_ST_VALID) begin
      norm_code = stage_q.code;
      norm_max = stage_q.max_code;
    end
  end

  // Divider sits in its own stage to keep the compare path short
  csdec_norm u_norm (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .code_in(norm_code),
    .max_code_in(norm_max),
    .frac_out(frac)
  );

  // Classification waits one cycle so it meets its own divider result
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stage2_q <= '0;
    end else begin
      stage2_q <= stage_q;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      valid2_q <= 1'b0;
    end else begin
      valid2_q <= valid_q;
    end
  end

  // Pulse rises with the edge that loads the new output word
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sig_valid_out <= 1'b0;
    end else begin
      sig_valid_out <= valid2_q;
    end
  end

  // Output word stands until the next answer
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sig_out <= '{state: CSDEC_ST_NA, value: `CSDEC_ZERO32, state_code: `CSDEC_ZERO32};
    end else if (valid2_q) begin
      sig_out.state <= stage2_q.state;
      sig_out.state_code <= stage2_q.state_code;
      sig_out.value <= csdec_value(stage2_q, frac);
    end
  end
endmodule : csdec_decoder

/* src/csdec_params.svh */
// Purpose: constants for the signal code decoder
// Assumes: 32-bit received code, low bits used for narrow types
// Notes: definitions only
`ifndef CSDEC_PARAMS_SVH
`define CSDEC_PARAMS_SVH
`define CSDEC_D4_SPEC_LO 32'h00000002
`define CSDEC_D4_SPEC_HI 32'h0000000D
`define CSDEC_D4_ERR 32'h0000000E
`define CSDEC_D4_NA 32'h0000000F
`define CSDEC_D2_ERR 32'h00000002
`define CSDEC_D2_NA 32'h00000003
`define CSDEC_C1_SPEC 32'h000000FB
`define CSDEC_C1_ERR 32'h000000FE
`define CSDEC_C1_NA 32'h000000FF
`define CSDEC_C2_SPEC 32'h0000FB00
`define CSDEC_C2_ERR 32'h0000FE00
`define CSDEC_C2_NA 32'h0000FF00
`define CSDEC_C4_SPEC 32'hFB000000
`define CSDEC_C4_ERR 32'hFE000000
`define CSDEC_C4_NA 32'hFF000000
`define CSDEC_MASK1 32'h00000001
`define CSDEC_MASK2 32'h00000003
`define CSDEC_MASK4 32'h0000000F
`define CSDEC_MASK8 32'h000000FF
`define CSDEC_MASK16 32'h0000FFFF
`define CSDEC_ZERO32 32'h00000000
`define CSDEC_ONE32 32'h00000001
`endif

/* src/csdec_pkg.sv */
// Purpose: types for the signal code decoder
// Assumes: nothing
// Notes: continuous value is unsigned fraction, 0 -> 0.0, all ones -> 1.0
package csdec_pkg;
  typedef enum logic [2:0] {
    CSDEC_TYPE_UNDEF = 3'h0,
    CSDEC_TYPE_D1 = 3'h1,
    CSDEC_TYPE_D2 = 3'h2,
    CSDEC_TYPE_D4 = 3'h3,
    CSDEC_TYPE_C1 = 3'h4,
    CSDEC_TYPE_C2 = 3'h5,
    CSDEC_TYPE_C4 = 3'h6
  } csdec_type_t;

  typedef enum logic [1:0] {
    CSDEC_ST_VALID = 2'h0,
    CSDEC_ST_SPECIAL = 2'h1,
    CSDEC_ST_ERROR = 2'h3,
    CSDEC_ST_NA = 2'h2
  } csdec_state_t;

  typedef struct packed {
    csdec_state_t state;
    logic [31:0] value;
    logic [31:0] state_code;
  } csdec_signal_t;
endpackage : csdec_pkg

/* src/csdec_norm.sv */
// Purpose: normalise a valid continuous code into a 0..1 fraction
// Assumes: code no greater than max_code, max_code nonzero
// Notes: registered output, one cycle; restoring division, 32 steps unrolled in a loop
`timescale 1ns/1ps
`include "csdec_params.svh"
module csdec_norm (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [31:0] code_in,
  input wire logic [31:0] max_code_in,
  output logic [31:0] frac_out
);
  // Full-scale code maps to all ones, so 1.0 is reachable
  function automatic logic [31:0] csdec_frac(input logic [31:0] num, input logic [31:0] den);
    logic [32:0] rem;
    logic [31:0] q;
    int i;
    rem = 33'h000000000;
    q = `CSDEC_ZERO32;
    if (num >= den) begin
      q = 32'hFFFFFFFF;
    end else begin
      rem = {1'b0, num};
      for (i = 31; i >= 0; i--) begin
        rem = {rem[31:0], 1'b0};
        if (rem >= {1'b0, den}) begin
          rem = rem - {1'b0, den};
          q[i] = 1'b1;
        end
      end
    end
    return q;
  endfunction : csdec_frac

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      frac_out <= `CSDEC_ZERO32;
    end else begin
      frac_out <= csdec_frac(code_in, max_code_in);
    end
  end
endmodule : csdec_norm

/* dv/csdec_chk.sv */
// Purpose: port assertions for the signal code decoder
// Assumes: one clock, output loads on the second edge after the take edge, seen at the third
// Notes: bound to every decoder instance
`timescale 1ns/1ps
module csdec_chk
  import csdec_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic code_valid_in,
  input wire logic [31:0] received_code_in,
  input csdec_type_t sig_type_in,
  input wire logic sig_valid_out,
  input csdec_signal_t sig_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence got(t, c);
    code_valid_in && sig_type_in == t && c ##3 1'b1;
  endsequence
  answer_late_a: assert property (code_valid_in |-> ##3 sig_valid_out)
    else $error("answer late");
  answer_spur_a: assert property (!$past(code_valid_in, 3) |-> !sig_valid_out)
    else $error("answer without request");
  value_zero_a: assert property (sig_valid_out && sig_out.state != CSDEC_ST_VALID |-> sig_out.value == 32'h0)
    else $error("value not zero");
  valid_code_a: assert property (sig_valid_out && sig_out.state == CSDEC_ST_VALID |-> sig_out.state_code == 32'h0)
    else $error("valid state code");
  d2_err_a: assert property (got(CSDEC_TYPE_D2, received_code_in[1:0] == 2'h2) |-> sig_out.state == CSDEC_ST_ERROR)
    else $error("d2 error");
  c1_spec_a: assert property (got(CSDEC_TYPE_C1, received_code_in[7:0] == 8'hFD) |->
    sig_out.state == CSDEC_ST_SPECIAL && sig_out.state_code == 32'h2) else $error("c1 special");
  c2_err_a: assert property (got(CSDEC_TYPE_C2, received_code_in[15:8] == 8'hFE) |->
    sig_out.state_code == {24'h0, $past(received_code_in[7:0], 3)}) else $error("c2 error");
  c4_na_a: assert property (got(CSDEC_TYPE_C4, received_code_in[31:24] == 8'hFF) |-> sig_out.state == CSDEC_ST_NA)
    else $error("c4 na");
  undef_na_a: assert property (got(CSDEC_TYPE_UNDEF, 1'b1) |-> sig_out.state == CSDEC_ST_NA)
    else $error("undef");
endmodule : csdec_chk
bind csdec_decoder csdec_chk u_chk (.sys_clk_in, .sys_rst_in, .code_valid_in, .received_code_in,
  .sig_type_in, .sig_valid_out, .sig_out);

/* dv/csdec_src.sv */
// Purpose: model of the field extractor feeding codes
// Assumes: requests launched on rising edges
// Notes: idle code lines inverted so stale data is never reused
`timescale 1ns/1ps
module csdec_src
  import csdec_pkg::*;
(
  input wire logic sys_clk_in,
  output logic code_valid_out,
  output logic [31:0] code_out,
  output csdec_type_t type_out
);
  initial begin
    code_valid_out = 1'b0;
    code_out = 32'h0;
    type_out = CSDEC_TYPE_UNDEF;
  end
  task automatic put(csdec_type_t t, logic [31:0] c);
    @(posedge sys_clk_in);
    code_valid_out <= 1'b1;
    code_out <= c;
    type_out <= t;
  endtask : put
  task automatic idle();
    @(posedge sys_clk_in);
    code_valid_out <= 1'b0;
    code_out <= ~code_out;
  endtask : idle
endmodule : csdec_src

/* dv/can_signal_code_decoder_tb.sv */
// Purpose: self-checking bench for the signal code decoder
// Assumes: fixed two-cycle answer latency
// Notes: fraction compared at zero, at full scale and at one truncated point
`timescale 1ns/1ps
module can_signal_code_decoder_tb
  import csdec_pkg::*;
;
  localparam csdec_state_t st_v = CSDEC_ST_VALID;
  localparam csdec_state_t st_s = CSDEC_ST_SPECIAL;
  localparam csdec_state_t st_e = CSDEC_ST_ERROR;
  localparam csdec_state_t st_n = CSDEC_ST_NA;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic vld;
  logic [31:0] code;
  csdec_type_t typ;
  logic sig_valid_out;
  csdec_signal_t sig_out;
  int n_fail = 0;
  int checks_done = 0;
  always #25 sys_clk_in = ~sys_clk_in;
  csdec_src src (.sys_clk_in(sys_clk_in), .code_valid_out(vld), .code_out(code), .type_out(typ));
  csdec_decoder dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .code_valid_in(vld),
    .received_code_in(code), .sig_type_in(typ), .sig_valid_out(sig_valid_out), .sig_out(sig_out));
  task automatic complete_run();
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic cmp(logic vo, csdec_state_t s, logic [31:0] v, logic [31:0] sc);
    checks_done++;
    if (sig_valid_out !== vo || sig_out !== {s, v, sc}) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, {sig_valid_out, sig_out}, {vo, s, v, sc});
    end
  endtask : cmp
  task automatic chk(csdec_type_t t, logic [31:0] c, csdec_state_t s, logic [31:0] v, logic [31:0] sc);
    src.put(t, c);
    src.idle();
    repeat (2) @(posedge sys_clk_in);
    #1;
    cmp(1'b1, s, v, sc);
  endtask : chk
  task automatic t_disc();
    for (int i = 0; i < 16; i++) begin
      chk(CSDEC_TYPE_D4, 32'(i), i < 2 ? st_v : i < 14 ? st_s : i == 14 ? st_e : st_n,
        i < 2 ? 32'(i) : 32'h0, i > 1 && i < 14 ? 32'(i - 2) : 32'h0);
      if (i < 4) chk(CSDEC_TYPE_D2, 32'(i), i < 2 ? st_v : i == 2 ? st_e : st_n, i < 2 ? 32'(i) : 32'h0, 32'h0);
      if (i < 2) chk(CSDEC_TYPE_D1, 32'(i), st_v, 32'(i), 32'h0);
    end
  endtask : t_disc
  task automatic rng(csdec_type_t t, logic [31:0] sp, logic [31:0] er, logic [31:0] na, logic [31:0] top);
    chk(t, sp - 32'h1, st_v, 32'hFFFFFFFF, 32'h0);
    chk(t, 32'h0, st_v, 32'h0, 32'h0);
    chk(t, sp, st_s, 32'h0, 32'h0);
    chk(t, er - 32'h1, st_s, 32'h0, er - 32'h1 - sp);
    chk(t, er, st_e, 32'h0, 32'h0);
    chk(t, na - 32'h1, st_e, 32'h0, na - 32'h1 - er);
    chk(t, top, st_n, 32'h0, 32'h0);
  endtask : rng
  task automatic t_b2b_reset();
    src.put(CSDEC_TYPE_D4, 32'h1);
    src.put(CSDEC_TYPE_C1, 32'h1);
    src.idle();
    @(posedge sys_clk_in);
    #1;
    cmp(1'b1, st_v, 32'h1, 32'h0);
    @(posedge sys_clk_in);
    #1;
    cmp(1'b1, st_v, 32'h010624DD, 32'h0);
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b1;
    @(posedge sys_clk_in);
    #1;
    cmp(1'b0, st_n, 32'h0, 32'h0);
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
  endtask : t_b2b_reset
  initial begin
    repeat (2) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    t_disc();
    rng(CSDEC_TYPE_C1, 32'hFB, 32'hFE, 32'hFF, 32'hFF);
    rng(CSDEC_TYPE_C2, 32'hFB00, 32'hFE00, 32'hFF00, 32'hFFFF);
    rng(CSDEC_TYPE_C4, 32'hFB000000, 32'hFE000000, 32'hFF000000, 32'hFFFFFFFF);
    chk(CSDEC_TYPE_C2, 32'h0000FE01, st_e, 32'h0, 32'h1);
    chk(CSDEC_TYPE_C4, 32'hFE000001, st_e, 32'h0, 32'h1);
    chk(CSDEC_TYPE_UNDEF, 32'h5, st_n, 32'h0, 32'h0);
    chk(csdec_type_t'(3'h7), 32'h1, st_n, 32'h0, 32'h0);
    t_b2b_reset();
    chk(CSDEC_TYPE_D2, 32'h3, st_n, 32'h0, 32'h0);
    complete_run();
  end
  // About 50 requests of four cycles; ample margin
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
endmodule : can_signal_code_decoder_tb
